// ---- inc/sfrb_pkg.sv ----
package sfrb_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 8;
	localparam int IDX_LSB = 2;
	localparam int BYTE_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PORT_A_PINS = 8'h05;
	localparam logic [7:0] IDX_CONV_RESULT = 8'h1e;
	localparam logic [7:0] IDX_CONV_CTRL_FIRST = 8'h1f;
	localparam logic [7:0] IDX_INDIRECT_DATA = 8'h80;
	localparam logic [7:0] IDX_OPTIONS = 8'h81;
	localparam logic [7:0] IDX_PC_LOW = 8'h82;
	localparam logic [7:0] IDX_CORE_STATUS = 8'h83;
	localparam logic [7:0] IDX_INDIRECT_PTR = 8'h84;
	localparam logic [7:0] IDX_DIR_A = 8'h85;
	localparam logic [7:0] IDX_DIR_B = 8'h86;
	localparam logic [7:0] IDX_DIR_C = 8'h87;
	localparam logic [7:0] IDX_DIR_D = 8'h88;
	localparam logic [7:0] IDX_DIR_E = 8'h89;
	localparam logic [7:0] IDX_PC_HIGH_BUF = 8'h8a;
	localparam logic [7:0] IDX_INT_CTRL = 8'h8b;
	localparam logic [7:0] IDX_PERIPH_IE = 8'h8c;
	localparam logic [7:0] IDX_POWER_CTRL = 8'h8e;
	localparam logic [7:0] IDX_TMR2_PERIOD = 8'h92;
	localparam logic [7:0] IDX_SLAVE_ADDR = 8'h93;
	localparam logic [7:0] IDX_SERIAL_STATUS = 8'h94;
	localparam logic [7:0] IDX_PIN_CONFIG = 8'h9f;

	////////////////////////////////////////////////////////////////////////////////
	// implemented (writable) bit masks
	localparam logic [7:0] MASK_ALL = 8'hff;
	localparam logic [7:0] MASK_SIX = 8'h3f;
	localparam logic [7:0] MASK_PC_HIGH = 8'h1f;
	localparam logic [7:0] MASK_STATUS_WR = 8'he7;
	localparam logic [7:0] MASK_STATUS_HOLD = 8'h07;
	localparam logic [7:0] MASK_PERIPH_IE = 8'hcf;
	localparam logic [7:0] MASK_POWER = 8'h02;
	localparam logic [7:0] MASK_SERIAL_WR = 8'hc0;
	localparam logic [7:0] MASK_PIN_CONFIG = 8'h07;
	localparam logic [7:0] MASK_INT_FLAGS = 8'h07;
	localparam logic [7:0] MASK_INT_HOLD = 8'h01;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// reset values (unknown bits are taken as zero)
	localparam logic [7:0] RST_OPTIONS = 8'hff;
	localparam logic [7:0] RST_DIR_SIX = 8'h3f;
	localparam logic [7:0] RST_DIR_EIGHT = 8'hff;
	localparam logic [7:0] RST_TMR2_PERIOD = 8'hff;
	localparam logic [7:0] RST_STATUS_POR = 8'h18;
	localparam int STATUS_TO_BIT = 4;
	localparam int STATUS_PD_BIT = 3;
	localparam logic [7:0] RST_PIN_CONFIG = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// port a digital masks: all-analog setting leaves only bit 4 digital
	localparam logic [2:0] PIN_CFG_ALL_ANALOG = 3'h0;
	localparam logic [5:0] PORT_A_PINS_DIG_ANALOG = 6'h10;
	localparam logic [5:0] PORT_A_PINS_DIG_ALL = 6'h3f;

	////////////////////////////////////////////////////////////////////////////////
	// indirect access sequencer
	typedef enum logic [1:0] {
		SFRB_IND_IDLE = 2'b00,
		SFRB_IND_REQ = 2'b01,
		SFRB_IND_WAIT = 2'b11,
		SFRB_IND_DONE = 2'b10
	} sfrb_ind_state_type;

	// control values driven to the core and peripherals
	typedef struct packed {
		logic [7:0] options;
		logic [7:0] pc_low;
		logic [7:0] pc_high_buffer;
		logic [7:0] core_status;
		logic [7:0] indirect_ptr;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
		logic [7:0] dir_d;
		logic [7:0] dir_e;
		logic [7:0] int_ctrl;
		logic [7:0] periph_ie;
		logic [7:0] power_ctrl;
		logic [7:0] tmr2_period;
		logic [7:0] slave_addr;
		logic [1:0] serial_ctrl;
		logic [2:0] pin_config;
		logic [7:0] conv_ctrl_first;
	} sfrb_ctrl_type;

	// state reported back by the core and peripherals
	typedef struct packed {
		logic timeout_flag;
		logic power_down_flag;
		logic [2:0] int_events;
		logic [5:0] serial_state;
		logic [7:0] conv_result;
	} sfrb_hw_type;

	// data memory port used by indirect access
	typedef struct packed {
		logic req;
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfrb_mem_type;

endpackage : sfrb_pkg

// ---- core/sfrb_indirect.sv ----
`timescale 1ns/100ps
`default_nettype none

module sfrb_indirect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic write,
	input wire logic [7:0] wdata,
	input wire logic [7:0] pointer,
	output sfrb_pkg::sfrb_mem_type mem,
	output logic capture,
	output logic done
);

	sfrb_pkg::sfrb_ind_state_type state_q, state_d;
	sfrb_pkg::sfrb_mem_type mem_q, mem_d;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer: request one cycle, memory answers next cycle, then complete
	always_comb begin
		state_d = state_q;
		mem_d = mem_q;
		mem_d.req = 1'b0;
		unique case (state_q)
			sfrb_pkg::SFRB_IND_IDLE: begin
				if (start) begin
					state_d = sfrb_pkg::SFRB_IND_REQ;
					mem_d.req = 1'b1;
					mem_d.we = write;
					mem_d.addr = pointer;
					mem_d.wdata = wdata;
				end
			end
			sfrb_pkg::SFRB_IND_REQ: state_d = sfrb_pkg::SFRB_IND_WAIT;
			sfrb_pkg::SFRB_IND_WAIT: state_d = sfrb_pkg::SFRB_IND_DONE;
			sfrb_pkg::SFRB_IND_DONE: state_d = sfrb_pkg::SFRB_IND_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= sfrb_pkg::SFRB_IND_IDLE;
			mem_q <= '0;
		end else begin
			state_q <= state_d;
			mem_q <= mem_d;
		end
	end

	// read data is valid while waiting; the owner samples it then
	assign mem = mem_q;
	assign capture = (state_q == sfrb_pkg::SFRB_IND_WAIT);
	assign done = (state_q == sfrb_pkg::SFRB_IND_DONE);

endmodule : sfrb_indirect

`default_nettype wire

// ---- core/sfrb_port_a.sv ----
`timescale 1ns/100ps
`default_nettype none

module sfrb_port_a #(
	parameter bit HAS_CONVERTER = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic warm_reset,
	input wire logic write,
	input wire logic [7:0] wdata,
	input wire logic [5:0] pins,
	input wire logic [2:0] pin_config,
	output logic [5:0] latch,
	output logic [7:0] read_value
);

	logic [5:0] latch_q, latch_d;
	logic [5:0] digital;

	////////////////////////////////////////////////////////////////////////////////
	// output latch; other resets leave it as it was
	always_comb begin
		latch_d = latch_q;
		if (!warm_reset && write) begin
			latch_d = wdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= '0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// analog pins read as zero, so after reset only bit 4 shows a pin level when HAS_CONVERTER is set
	always_comb begin
		digital = sfrb_pkg::PORT_A_PINS_DIG_ALL;
		if (HAS_CONVERTER && pin_config == sfrb_pkg::PIN_CFG_ALL_ANALOG) begin
			digital = sfrb_pkg::PORT_A_PINS_DIG_ANALOG;
		end
	end

	assign latch = latch_q;
	assign read_value = {2'b00, pins & digital};

endmodule : sfrb_port_a

`default_nettype wire

// ---- core/sfrb_bank1.sv ----
`timescale 1ns/100ps
`default_nettype none

module sfrb_bank1 #(
	parameter bit HAS_CONVERTER = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic warm_reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sfrb_pkg::ADDR_W-1:0] paddr,
	input wire logic [sfrb_pkg::DATA_W-1:0] pwdata,
	output logic [sfrb_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sfrb_pkg::sfrb_hw_type hw,
	input wire logic [5:0] port_a_pins,
	output logic [5:0] port_a_latch,
	output logic [5:0] port_a_direction,
	output sfrb_pkg::sfrb_ctrl_type ctrl,
	output sfrb_pkg::sfrb_mem_type mem,
	input wire logic [7:0] mem_rdata
);

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	logic [sfrb_pkg::IDX_W-1:0] idx;
	logic addr_ok;
	logic setup;
	logic access;
	logic is_indirect;
	logic wr_en;
	logic [7:0] wbyte;
	logic ind_capture;
	logic ind_done;
	logic port_a_pins_wr;
	logic [7:0] port_a_pins_read;

	// top address bits outside the bank decode as unmapped
	assign idx = paddr[sfrb_pkg::IDX_LSB +: sfrb_pkg::IDX_W];
	assign addr_ok = (paddr[sfrb_pkg::ADDR_W-1:sfrb_pkg::IDX_LSB+sfrb_pkg::IDX_W] == '0);
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign is_indirect = addr_ok && (idx == sfrb_pkg::IDX_INDIRECT_DATA);
	assign wr_en = access && pwrite && addr_ok && !is_indirect;
	assign wbyte = pwdata[sfrb_pkg::BYTE_W-1:0];
	assign port_a_pins_wr = wr_en && (idx == sfrb_pkg::IDX_PORT_A_PINS);

	// plain registers answer at once, indirect ones after the memory round trip
	assign pready = !is_indirect || ind_done;
	assign pslverr = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] opt_q, opt_d;
	logic [7:0] pcl_q, pcl_d;
	logic [7:0] stat_q, stat_d;
	logic [7:0] ptr_q, ptr_d;
	logic [7:0] dir_a_q, dir_a_d;
	logic [7:0] dir_b_q, dir_b_d;
	logic [7:0] dir_c_q, dir_c_d;
	logic [7:0] dir_d_q, dir_d_d;
	logic [7:0] dir_e_q, dir_e_d;
	logic [7:0] pch_q, pch_d;
	logic [7:0] intc_q, intc_d;
	logic [7:0] pie_q, pie_d;
	logic [7:0] power_control_flags_q, power_control_flags_d;
	logic [7:0] per_q, per_d;
	logic [7:0] sadd_q, sadd_d;
	logic [7:0] sctl_q, sctl_d;
	logic [7:0] pcfg_q, pcfg_d;
	logic [7:0] cctl_q, cctl_d;
	logic [sfrb_pkg::DATA_W-1:0] prdata_q, prdata_d;
	logic [7:0] rd_byte;

	// merge written bits into the old value; bits outside the mask never move
	function automatic logic [7:0] merge(
		input logic [7:0] old,
		input logic [7:0] val,
		input logic [7:0] mask
	);
		merge = (old & ~mask) | (val & mask);
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////
	// next-value logic for the register file
	always_comb begin
		opt_d = opt_q;
		pcl_d = pcl_q;
		stat_d = stat_q;
		ptr_d = ptr_q;
		dir_a_d = dir_a_q;
		dir_b_d = dir_b_q;
		dir_c_d = dir_c_q;
		dir_d_d = dir_d_q;
		dir_e_d = dir_e_q;
		pch_d = pch_q;
		intc_d = intc_q;
		pie_d = pie_q;
		power_control_flags_d = power_control_flags_q;
		per_d = per_q;
		sadd_d = sadd_q;
		sctl_d = sctl_q;
		pcfg_d = pcfg_q;
		cctl_d = cctl_q;
		if (warm_reset) begin
			// other resets: most fields reload, a few hold their value
			opt_d = sfrb_pkg::RST_OPTIONS;
			pcl_d = sfrb_pkg::ZERO_BYTE;
			stat_d = stat_q & sfrb_pkg::MASK_STATUS_HOLD;
			stat_d[sfrb_pkg::STATUS_TO_BIT] = hw.timeout_flag;
			stat_d[sfrb_pkg::STATUS_PD_BIT] = hw.power_down_flag;
			dir_a_d = sfrb_pkg::RST_DIR_SIX;
			dir_b_d = sfrb_pkg::RST_DIR_EIGHT;
			dir_c_d = sfrb_pkg::RST_DIR_SIX;
			dir_d_d = sfrb_pkg::RST_DIR_EIGHT;
			dir_e_d = sfrb_pkg::RST_DIR_EIGHT;
			pch_d = sfrb_pkg::ZERO_BYTE;
			intc_d = intc_q & sfrb_pkg::MASK_INT_HOLD;
			pie_d = sfrb_pkg::ZERO_BYTE;
			per_d = sfrb_pkg::RST_TMR2_PERIOD;
			sadd_d = sfrb_pkg::ZERO_BYTE;
			sctl_d = sfrb_pkg::ZERO_BYTE;
			pcfg_d = sfrb_pkg::RST_PIN_CONFIG;
			cctl_d = sfrb_pkg::ZERO_BYTE;
		end else begin
			if (wr_en) begin
				unique case (idx)
					sfrb_pkg::IDX_OPTIONS: opt_d = wbyte;
					sfrb_pkg::IDX_PC_LOW: pcl_d = wbyte;
					sfrb_pkg::IDX_CORE_STATUS: begin
						stat_d = merge(stat_q, wbyte, sfrb_pkg::MASK_STATUS_WR);
					end
					sfrb_pkg::IDX_INDIRECT_PTR: ptr_d = wbyte;
					sfrb_pkg::IDX_DIR_A: dir_a_d = merge(dir_a_q, wbyte, sfrb_pkg::MASK_SIX);
					sfrb_pkg::IDX_DIR_B: dir_b_d = wbyte;
					sfrb_pkg::IDX_DIR_C: dir_c_d = merge(dir_c_q, wbyte, sfrb_pkg::MASK_SIX);
					sfrb_pkg::IDX_DIR_D: dir_d_d = wbyte;
					sfrb_pkg::IDX_DIR_E: dir_e_d = wbyte;
					sfrb_pkg::IDX_PC_HIGH_BUF: begin
						pch_d = merge(pch_q, wbyte, sfrb_pkg::MASK_PC_HIGH);
					end
					sfrb_pkg::IDX_INT_CTRL: intc_d = wbyte;
					sfrb_pkg::IDX_PERIPH_IE: begin
						pie_d = merge(pie_q, wbyte, sfrb_pkg::MASK_PERIPH_IE);
					end
					sfrb_pkg::IDX_POWER_CTRL: begin
						power_control_flags_d = merge(power_control_flags_q, wbyte, sfrb_pkg::MASK_POWER);
					end
					sfrb_pkg::IDX_TMR2_PERIOD: per_d = wbyte;
					sfrb_pkg::IDX_SLAVE_ADDR: sadd_d = wbyte;
					sfrb_pkg::IDX_SERIAL_STATUS: begin
						sctl_d = merge(sctl_q, wbyte, sfrb_pkg::MASK_SERIAL_WR);
					end
					sfrb_pkg::IDX_PIN_CONFIG: begin
						if (HAS_CONVERTER) begin
							pcfg_d = merge(pcfg_q, wbyte, sfrb_pkg::MASK_PIN_CONFIG);
						end
					end
					sfrb_pkg::IDX_CONV_CTRL_FIRST: begin
						// bit 1 is stored as written; keeping it clear is up to software
						if (HAS_CONVERTER) begin
							cctl_d = wbyte;
						end
					end
					default: ;
				endcase
			end
			// hardware flag events win over a clear in the same cycle
			intc_d = intc_d | {5'b00000, hw.int_events};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// power-on values differ from those of other resets
			opt_q <= sfrb_pkg::RST_OPTIONS;
			pcl_q <= sfrb_pkg::ZERO_BYTE;
			stat_q <= sfrb_pkg::RST_STATUS_POR;
			ptr_q <= sfrb_pkg::ZERO_BYTE;
			dir_a_q <= sfrb_pkg::RST_DIR_SIX;
			dir_b_q <= sfrb_pkg::RST_DIR_EIGHT;
			dir_c_q <= sfrb_pkg::RST_DIR_SIX;
			dir_d_q <= sfrb_pkg::RST_DIR_EIGHT;
			dir_e_q <= sfrb_pkg::RST_DIR_EIGHT;
			pch_q <= sfrb_pkg::ZERO_BYTE;
			intc_q <= sfrb_pkg::ZERO_BYTE;
			pie_q <= sfrb_pkg::ZERO_BYTE;
			power_control_flags_q <= sfrb_pkg::ZERO_BYTE;
			per_q <= sfrb_pkg::RST_TMR2_PERIOD;
			sadd_q <= sfrb_pkg::ZERO_BYTE;
			sctl_q <= sfrb_pkg::ZERO_BYTE;
			pcfg_q <= sfrb_pkg::RST_PIN_CONFIG;
			cctl_q <= sfrb_pkg::ZERO_BYTE;
		end else begin
			opt_q <= opt_d;
			pcl_q <= pcl_d;
			stat_q <= stat_d;
			ptr_q <= ptr_d;
			dir_a_q <= dir_a_d;
			dir_b_q <= dir_b_d;
			dir_c_q <= dir_c_d;
			dir_d_q <= dir_d_d;
			dir_e_q <= dir_e_d;
			pch_q <= pch_d;
			intc_q <= intc_d;
			pie_q <= pie_d;
			power_control_flags_q <= power_control_flags_d;
			per_q <= per_d;
			sadd_q <= sadd_d;
			sctl_q <= sctl_d;
			pcfg_q <= pcfg_d;
			cctl_q <= cctl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; anything not listed reads zero
	always_comb begin
		rd_byte = sfrb_pkg::ZERO_BYTE;
		if (addr_ok) begin
			unique case (idx)
				sfrb_pkg::IDX_PORT_A_PINS: rd_byte = port_a_pins_read;
				sfrb_pkg::IDX_CONV_RESULT: begin
					rd_byte = HAS_CONVERTER ? hw.conv_result : sfrb_pkg::ZERO_BYTE;
				end
				sfrb_pkg::IDX_CONV_CTRL_FIRST: rd_byte = cctl_q;
				sfrb_pkg::IDX_OPTIONS: rd_byte = opt_q;
				sfrb_pkg::IDX_PC_LOW: rd_byte = pcl_q;
				sfrb_pkg::IDX_CORE_STATUS: rd_byte = stat_q;
				sfrb_pkg::IDX_INDIRECT_PTR: rd_byte = ptr_q;
				sfrb_pkg::IDX_DIR_A: rd_byte = dir_a_q;
				sfrb_pkg::IDX_DIR_B: rd_byte = dir_b_q;
				sfrb_pkg::IDX_DIR_C: rd_byte = dir_c_q;
				sfrb_pkg::IDX_DIR_D: rd_byte = dir_d_q;
				sfrb_pkg::IDX_DIR_E: rd_byte = dir_e_q;
				sfrb_pkg::IDX_PC_HIGH_BUF: rd_byte = pch_q;
				sfrb_pkg::IDX_INT_CTRL: rd_byte = intc_q;
				sfrb_pkg::IDX_PERIPH_IE: rd_byte = pie_q;
				sfrb_pkg::IDX_POWER_CTRL: rd_byte = power_control_flags_q;
				sfrb_pkg::IDX_TMR2_PERIOD: rd_byte = per_q;
				sfrb_pkg::IDX_SLAVE_ADDR: rd_byte = sadd_q;
				sfrb_pkg::IDX_SERIAL_STATUS: rd_byte = sctl_q | {2'b00, hw.serial_state};
				sfrb_pkg::IDX_PIN_CONFIG: rd_byte = pcfg_q;
				default: rd_byte = sfrb_pkg::ZERO_BYTE;
			endcase
		end
	end

	// read data is registered in the setup cycle, or from memory for indirect reads
	always_comb begin
		prdata_d = prdata_q;
		if (ind_capture) begin
			prdata_d = {{(sfrb_pkg::DATA_W-sfrb_pkg::BYTE_W){1'b0}}, mem_rdata};
		end else if (setup) begin
			prdata_d = {{(sfrb_pkg::DATA_W-sfrb_pkg::BYTE_W){1'b0}}, rd_byte};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// indirect access and port a
	sfrb_indirect u_indirect (
		.pclk(pclk),
		.presetn(presetn),
		.start(access && is_indirect && !ind_done),
		.write(pwrite),
		.wdata(wbyte),
		.pointer(ptr_q),
		.mem(mem),
		.capture(ind_capture),
		.done(ind_done)
	);

	sfrb_port_a #(
		.HAS_CONVERTER(HAS_CONVERTER)
	) u_port_a (
		.pclk(pclk),
		.presetn(presetn),
		.warm_reset(warm_reset),
		.write(port_a_pins_wr),
		.wdata(wbyte),
		.pins(port_a_pins),
		.pin_config(pcfg_q[2:0]),
		.latch(port_a_latch),
		.read_value(port_a_pins_read)
	);

	// register contents steer the core and peripherals
	assign port_a_direction = dir_a_q[5:0];
	assign ctrl.options = opt_q;
	assign ctrl.pc_low = pcl_q;
	assign ctrl.pc_high_buffer = pch_q;
	assign ctrl.core_status = stat_q;
	assign ctrl.indirect_ptr = ptr_q;
	assign ctrl.dir_b = dir_b_q;
	assign ctrl.dir_c = dir_c_q;
	assign ctrl.dir_d = dir_d_q;
	assign ctrl.dir_e = dir_e_q;
	assign ctrl.int_ctrl = intc_q;
	assign ctrl.periph_ie = pie_q;
	assign ctrl.power_ctrl = power_control_flags_q;
	assign ctrl.tmr2_period = per_q;
	assign ctrl.slave_addr = sadd_q;
	assign ctrl.serial_ctrl = sctl_q[7:6];
	assign ctrl.pin_config = pcfg_q[2:0];
	assign ctrl.conv_ctrl_first = cctl_q;

endmodule : sfrb_bank1

`default_nettype wire

// ---- bench/sfrb_bank1_sva.sv ----
`timescale 1ns/100ps
`default_nettype none

module sfrb_bank1_sva #(
	parameter bit HAS_CONVERTER = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic warm_reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sfrb_pkg::ADDR_W-1:0] paddr,
	input wire logic [sfrb_pkg::DATA_W-1:0] pwdata,
	input wire logic [sfrb_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire sfrb_pkg::sfrb_hw_type hw,
	input wire sfrb_pkg::sfrb_ctrl_type ctrl,
	input wire sfrb_pkg::sfrb_mem_type mem
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////
	// setup cycles by target; unmapped covers high address bits too
	logic ind_setup;
	logic bad_setup;
	logic conv_setup;
	assign ind_setup = psel && !penable && paddr[11:10] == 2'b00 && paddr[9:2] == 8'h80;
	assign bad_setup = psel && !penable && (paddr[11:10] != 2'b00 ||
		paddr[9:2] inside {8'h8d, 8'h8f, [8'h90:8'h91], [8'h95:8'h9e]});
	assign conv_setup = psel && !penable && paddr[11:10] == 2'b00 &&
		paddr[9:2] inside {8'h1e, 8'h1f, 8'h9f};

	// indirect access: three wait states, memory request two cycles after setup
	sequence s_ind_wait;
		!pready [*3] ##1 pready;
	endsequence
	sequence s_ind_req;
		##2 mem.req && mem.addr == ctrl.indirect_ptr && mem.we == pwrite;
	endsequence

	////////////////////////////////////////////////////////////////
	a_slverr_low: assert property (!pslverr)
		else $error("error response seen");
	a_unmapped_zero: assert property (bad_setup |=> prdata == '0)
		else $error("unmapped read not zero");
	a_conv_absent: assert property (!HAS_CONVERTER && conv_setup |=> prdata == '0)
		else $error("absent converter register read not zero");
	a_ind_wait: assert property (ind_setup |=> s_ind_wait)
		else $error("indirect answer timing wrong");
	a_ind_req: assert property (ind_setup |-> s_ind_req)
		else $error("indirect memory request wrong");
	a_ind_wdata: assert property (ind_setup && pwrite |-> ##2 mem.wdata == pwdata[7:0])
		else $error("indirect write data wrong");
	a_req_pulse: assert property ($rose(mem.req) |=> !mem.req)
		else $error("memory request longer than one cycle");
	a_status_por: assert property ($rose(presetn) |-> ctrl.core_status == 8'h18)
		else $error("power-on status wrong");
	a_status_warm: assert property (warm_reset |=> ctrl.core_status == {3'b000,
		$past(hw.timeout_flag), $past(hw.power_down_flag), $past(ctrl.core_status[2:0])})
		else $error("warm reset status wrong");
	a_warm_reload: assert property (warm_reset |=> ctrl.options == 8'hff &&
		$stable(ctrl.indirect_ptr) && $stable(ctrl.power_ctrl))
		else $error("warm reset reload wrong");
endmodule : sfrb_bank1_sva

`default_nettype wire

// ---- bench/sfrb_bank1_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module sfrb_bank1_tb;
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] rst;
		logic [7:0] wv;
		logic [7:0] exp;
	} sfrb_row_type;
	// index, first read, written, read back
	localparam sfrb_row_type ROWS [22] = '{
		'{8'h81, 8'hff, 8'ha5, 8'ha5}, '{8'h82, 8'h00, 8'ha5, 8'ha5},
		'{8'h83, 8'h18, 8'ha5, 8'hbd}, '{8'h84, 8'h00, 8'ha5, 8'ha5},
		'{8'h85, 8'h3f, 8'ha5, 8'h25}, '{8'h86, 8'hff, 8'ha5, 8'ha5},
		'{8'h87, 8'h3f, 8'ha5, 8'h25}, '{8'h88, 8'hff, 8'ha5, 8'ha5},
		'{8'h89, 8'hff, 8'ha5, 8'ha5}, '{8'h8a, 8'h00, 8'ha5, 8'h05},
		'{8'h8b, 8'h00, 8'ha5, 8'ha5}, '{8'h8e, 8'h00, 8'hff, 8'h02},
		'{8'h8c, 8'h00, 8'hbf, 8'h8f},
		'{8'h1f, 8'h00, 8'hfd, 8'hfd},
		'{8'h92, 8'hff, 8'ha5, 8'ha5}, '{8'h93, 8'h00, 8'ha5, 8'ha5},
		'{8'h94, 8'h00, 8'hff, 8'hc0}, '{8'h9f, 8'h00, 8'hff, 8'h07},
		'{8'h1e, 8'h5a, 8'hff, 8'h5a}, '{8'h8d, 8'h00, 8'hff, 8'h00},
		'{8'h90, 8'h00, 8'hff, 8'h00}, '{8'h9e, 8'h00, 8'hff, 8'h00}};

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic warm_reset = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, prdata_nc, rd0, rd1;
	logic pready, pready_nc, pslverr;
	logic [1:0] hi_bits = 2'b00;
	sfrb_pkg::sfrb_hw_type hw = {2'b00, 3'h0, 6'h00, 8'h5a};
	logic [5:0] port_a_pins = 6'h3f;
	logic [5:0] port_a_latch, port_a_direction;
	sfrb_pkg::sfrb_ctrl_type ctrl;
	sfrb_pkg::sfrb_mem_type mem;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] ram [256];
	int n_fail = 0;
	int check_count = 0;

	////////////////////////////////////////////////////////////////
	// second instance has no converter and shares every bus input
	sfrb_bank1 dut_u (.pclk, .presetn, .warm_reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .hw, .port_a_pins, .port_a_latch,
		.port_a_direction, .ctrl, .mem, .mem_rdata);
	sfrb_bank1 #(.HAS_CONVERTER(1'b0)) nc_u (.pclk, .presetn, .warm_reset, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata(prdata_nc), .pready(pready_nc), .pslverr(),
		.hw, .port_a_pins, .port_a_latch(), .port_a_direction(), .ctrl(), .mem(), .mem_rdata);

	always #2 pclk = ~pclk;

	// data memory answers in the cycle after a request
	always @(posedge pclk) begin
		if (mem.req) begin
			mem_rdata <= ram[mem.addr];
			if (mem.we) ram[mem.addr] <= mem.wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] e, input logic [31:0] got);
		check_count++;
		if (got !== {24'h00_0000, e}) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, {24'h00_0000, e}, got);
		end
	endtask : chk

	// one transfer; bus stays selected so the next setup may follow at once
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wv);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {hi_bits, idx, 2'b00};
		pwdata <= {24'h00_0000, wv};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n == 50) chk("pready", 8'h01, 32'h0000_0000);
		rd0 = prdata;
		rd1 = prdata_nc;
	endtask : apb

	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : idle

	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////
	// watchdog: the tests need well under a thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		close_out();
	end

	initial begin
		string nm;
		ram[8'h41] = 8'h3c;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h05, 8'h00);
		chk("port a, analog", 8'h10, rd0);
		foreach (ROWS[i]) begin
			nm = $sformatf("index %h", ROWS[i].idx);
			apb(1'b0, ROWS[i].idx, 8'h00);
			chk(nm, ROWS[i].rst, rd0);
			apb(1'b1, ROWS[i].idx, ROWS[i].wv);
			apb(1'b0, ROWS[i].idx, 8'h00);
			chk(nm, ROWS[i].exp, rd0);
			chk(nm, (ROWS[i].idx inside {8'h1e, 8'h1f, 8'h9f}) ? 8'h00 : ROWS[i].exp, rd1);
		end
		apb(1'b1, 8'h05, 8'h2a);
		apb(1'b0, 8'h05, 8'h00);
		chk("port a, digital", 8'h3f, rd0);
		idle();
		$display("test register map done");
		// warm reset: status takes flags, low bits held, pointer and latch held
		hw.power_down_flag <= 1'b1;
		warm_reset <= 1'b1;
		@(posedge pclk);
		warm_reset <= 1'b0;
		@(posedge pclk);
		apb(1'b0, 8'h83, 8'h00);
		chk("status after warm", 8'h0d, rd0);
		apb(1'b0, 8'h8b, 8'h00);
		chk("interrupt control after warm", 8'h01, rd0);
		apb(1'b0, 8'h81, 8'h00);
		chk("options after warm", 8'hff, rd0);
		apb(1'b0, 8'h84, 8'h00);
		chk("pointer after warm", 8'ha5, rd0);
		apb(1'b0, 8'h8e, 8'h00);
		chk("power flags after warm", 8'h02, rd0);
		apb(1'b0, 8'h05, 8'h00);
		chk("port a after warm", 8'h10, rd0);
		chk("port a latch", 8'h2a, {26'h000_0000, port_a_latch});
		chk("port a direction", 8'h3f, {26'h000_0000, port_a_direction});
		idle();
		$display("test warm reset done");
		// high address bits set: nothing is reached; blocking so the next call sees it
		hi_bits = 2'b01;
		apb(1'b1, 8'h81, 8'h00);
		apb(1'b0, 8'h81, 8'h00);
		chk("outside map", 8'h00, rd0);
		idle();
		hi_bits = 2'b00;
		apb(1'b0, 8'h81, 8'h00);
		chk("options kept", 8'hff, rd0);
		$display("test outside map done");
		// indirect location works on memory at the pointer
		apb(1'b1, 8'h84, 8'h40);
		apb(1'b1, 8'h80, 8'hc3);
		apb(1'b0, 8'h80, 8'h00);
		chk("indirect read back", 8'hc3, rd0);
		chk("memory at pointer", 8'hc3, {24'h00_0000, ram[8'h40]});
		apb(1'b1, 8'h84, 8'h41);
		apb(1'b0, 8'h80, 8'h00);
		chk("indirect at new pointer", 8'h3c, rd0);
		idle();
		$display("test indirect done");
		close_out();
	end
endmodule : sfrb_bank1_tb

bind sfrb_bank1 sfrb_bank1_sva #(.HAS_CONVERTER(HAS_CONVERTER)) chk_u (.pclk, .presetn,
	.warm_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.hw, .ctrl, .mem);

`default_nettype wire
